/* logic/indctl_pkg.sv */
package indctl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  // half periods of the two shared blink timers
  localparam int unsigned RATE1_HALF_NS = 40000000;
  localparam int unsigned RATE2_HALF_NS = 80000000;
  localparam int unsigned RATE1_HALF_CYCLES = RATE1_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned RATE2_HALF_CYCLES = RATE2_HALF_NS / CLK_PERIOD_NS;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_IND_A = 16'hf020;
  localparam logic [15:0] IDX_IND_B = 16'hf021;
  localparam logic [15:0] IDX_MP = 16'hf022;
  localparam logic [31:0] ADDR_IND_A = {14'h0000, IDX_IND_A, 2'h0};
  localparam logic [31:0] ADDR_IND_B = {14'h0000, IDX_IND_B, 2'h0};
  localparam logic [31:0] ADDR_MP = {14'h0000, IDX_MP, 2'h0};

  // control word layout
  localparam int unsigned FLASH_LSB = 8;
  localparam int unsigned DUAL_LSB = 10;
  localparam int unsigned STEADY_LSB = 4;
  localparam int unsigned RATE_BIT = 2;
  localparam int unsigned SENSE_LSB = 0;
  localparam logic [15:0] CTL_WMASK = 16'h0ff7;

  localparam logic [15:0] RST_IND_A = 16'h0160;
  localparam logic [15:0] RST_IND_B = 16'h0160;
  localparam logic [15:0] RST_MP = 16'h0000;

  // behaviour codes
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_TXRX = 4'h1;
  localparam logic [3:0] CODE_TX = 4'h2;
  localparam logic [3:0] CODE_RX = 4'h3;
  localparam logic [3:0] CODE_LINK = 4'h6;
  localparam logic [3:0] CODE_ON = 4'h7;
  localparam logic [3:0] CODE_BLINK_MIX = 4'ha;
  localparam logic [3:0] CODE_SOLID_MIX = 4'hb;
  localparam logic [1:0] DUAL_SEL = 2'h2;

  // drive sense
  localparam logic [1:0] SENSE_LOW_PUSH = 2'h0;
  localparam logic [1:0] SENSE_HIGH_PUSH = 2'h1;
  localparam logic [1:0] SENSE_LOW_OD = 2'h2;
  localparam logic [1:0] SENSE_HIGH_OD = 2'h3;

  typedef struct packed {
    logic tx;
    logic rx;
    logic link;
  } indctl_src_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } indctl_pin_t;

  function automatic logic cond_hit(input logic [3:0] code, input indctl_src_t src,
                                    input logic mix_ok);
    logic hit;
    hit = 1'b0;
    case (code)
      CODE_TXRX: hit = src.tx | src.rx;
      CODE_TX: hit = src.tx;
      CODE_RX: hit = src.rx;
      CODE_LINK: hit = src.link;
      CODE_ON: hit = 1'b1;
      CODE_BLINK_MIX, CODE_SOLID_MIX: hit = mix_ok;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

/* logic/indctl_blink_timer.sv */
`timescale 1ns/100ps
module indctl_blink_timer #(
  parameter int unsigned HALF_CYCLES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic wave
);
  import indctl_pkg::*;

  logic [31:0] cnt_ff;
  logic wave_ff;
  logic [31:0] last_cnt;

  assign last_cnt = 32'(HALF_CYCLES - 1);
  assign wave = wave_ff;

  // one free-running timer per rate, shared by every pin so they blink in phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h0;
      wave_ff <= 1'b0;
    end else if (cnt_ff >= last_cnt) begin
      cnt_ff <= 32'h0;
      wave_ff <= ~wave_ff;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  chk_wave_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_ff < last_cnt) |=> (wave_ff == $past(wave_ff)))
    else $error("blink wave toggled before its half period");

  chk_wave_flip: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_ff == last_cnt) |=> (wave_ff != $past(wave_ff)) && (cnt_ff == 32'h0))
    else $error("blink wave did not toggle at end of half period");

endmodule // indctl_blink_timer

/* logic/indctl_pin_drive.sv */
`timescale 1ns/100ps
module indctl_pin_drive (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_on,
  input wire logic [1:0] sense,
  output indctl_pkg::indctl_pin_t pin
);
  import indctl_pkg::*;

  indctl_pin_t pin_ff;
  indctl_pin_t nxt_pin;

  always_comb begin
    nxt_pin = '{level: 1'b1, oe_n: 1'b0};
    case (sense)
      SENSE_LOW_PUSH: nxt_pin = '{level: ~pin_on, oe_n: 1'b0};
      SENSE_HIGH_PUSH: nxt_pin = '{level: pin_on, oe_n: 1'b0};
      SENSE_LOW_OD: nxt_pin = '{level: 1'b0, oe_n: ~pin_on};
      SENSE_HIGH_OD: nxt_pin = '{level: 1'b1, oe_n: ~pin_on};
      default: nxt_pin = '{level: 1'b1, oe_n: 1'b0};
    endcase
  end

  // registered so the pin never glitches while sources change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= '{level: 1'b1, oe_n: 1'b0};
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign pin = pin_ff;

  chk_sense_low_push: assert property (@(posedge pclk) disable iff (!presetn)
    (sense == SENSE_LOW_PUSH) |=> (pin.oe_n == 1'b0) && (pin.level == !$past(pin_on)))
    else $error("sense 00 pin level wrong");

  chk_sense_high_push: assert property (@(posedge pclk) disable iff (!presetn)
    (sense == SENSE_HIGH_PUSH) |=> (pin.oe_n == 1'b0) && (pin.level == $past(pin_on)))
    else $error("sense 01 pin level wrong");

  chk_sense_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
    sense[1] |=> (pin.oe_n == !$past(pin_on)) && (pin.level == $past(sense[0])))
    else $error("tristate sense pin drive wrong");

endmodule // indctl_pin_drive

/* logic/indctl_top.sv */
// Function
// - an active blink condition overrides the solid behaviour for a pin's on state.
// - code 0000 holds the indicator off, 0111 holds it on, 0001 follows tx or rx activity.
// - on system-side indicators 0010 follows transmit only and 0011 receive only.
// - solid code 0110 on indicator a and the multipurpose pin follows system link.
// - indicator b takes line-side sources: 0001 tx or rx, 0010 tx, 0011 rx, 0110 link.
// - indicator b behaviour and rate fields are ignored when indicator a bits 11:10 are 10.
// - the multipurpose blink field also accepts 1010 blink mix and 1011 solid mix.
// - a rate pick of 0 selects blink rate 1 and 1 selects blink rate 2.
// - drive sense 00 drives the pin low when on and high when off.
// - drive sense 01 drives the pin high when on and low when off.
// - sense 10 drives low when on, 11 high when on, and both release the pin when off.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module indctl_top #(
  parameter int unsigned RATE1_CYCLES = indctl_pkg::RATE1_HALF_CYCLES,
  parameter int unsigned RATE2_CYCLES = indctl_pkg::RATE2_HALF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire indctl_pkg::indctl_src_t sys_src,
  input wire indctl_pkg::indctl_src_t line_src,
  output indctl_pkg::indctl_pin_t indicator_a_pin,
  output indctl_pkg::indctl_pin_t indicator_b_pin,
  output indctl_pkg::indctl_pin_t multipurpose_pin
);
  import indctl_pkg::*;

  logic [15:0] indicator_a_control_ff;
  logic [15:0] indicator_b_control_ff;
  logic [15:0] multipurpose_pin_control_ff;
  logic [31:0] prdata_ff;
  logic [15:0] rd_word;
  logic hit_a;
  logic hit_b;
  logic hit_mp;
  logic mapped;
  logic setup_phase;
  logic write_take;
  logic wave1;
  logic wave2;
  logic dual_mode;
  logic a_on;
  logic b_own_on;
  logic b_on;
  logic mp_on;

  // merge a bus write into a 16-bit control word, honouring byte strobes
  function automatic logic [15:0] merge_write(input logic [15:0] old, input logic [31:0] wdata,
                                              input logic [3:0] strb);
    logic [15:0] merged;
    merged = old;
    if (strb[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = wdata[15:8];
    end
    return merged & CTL_WMASK;
  endfunction

  // on state of one pin from its control word
  function automatic logic pin_state(input logic [15:0] ctl, input indctl_src_t src,
                                     input logic mix_ok, input logic w1, input logic w2);
    logic [3:0] flash;
    logic [3:0] steady;
    logic wave;
    logic on;
    flash = ctl[FLASH_LSB +: 4];
    steady = ctl[STEADY_LSB +: 4];
    wave = ctl[RATE_BIT] ? w2 : w1;
    if (cond_hit(flash, src, mix_ok)) begin
      on = (mix_ok && flash == CODE_SOLID_MIX) ? 1'b1 : wave;
    end else begin
      // solid field never takes mix codes: top bit set reads as off
      on = cond_hit(steady, src, 1'b0);
    end
    return on;
  endfunction

  // bus decode
  assign hit_a = (paddr == ADDR_IND_A);
  assign hit_b = (paddr == ADDR_IND_B);
  assign hit_mp = (paddr == ADDR_MP);
  assign mapped = hit_a | hit_b | hit_mp;
  assign setup_phase = psel & ~penable;
  assign write_take = psel & penable & pwrite;

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;

  always_comb begin
    rd_word = 16'h0000;
    if (hit_a) begin
      rd_word = indicator_a_control_ff;
    end else if (hit_b) begin
      rd_word = indicator_b_control_ff;
    end else if (hit_mp) begin
      rd_word = multipurpose_pin_control_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_ff <= {16'h0000, rd_word};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_a_control_ff <= RST_IND_A;
    end else if (write_take && hit_a) begin
      indicator_a_control_ff <= merge_write(indicator_a_control_ff, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_b_control_ff <= RST_IND_B;
    end else if (write_take && hit_b) begin
      indicator_b_control_ff <= merge_write(indicator_b_control_ff, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multipurpose_pin_control_ff <= RST_MP;
    end else if (write_take && hit_mp) begin
      multipurpose_pin_control_ff <= merge_write(multipurpose_pin_control_ff, pwdata, pstrb);
    end
  end

  // shared rate timers
  indctl_blink_timer #(
    .HALF_CYCLES(RATE1_CYCLES)
  ) u_rate1 (
    .pclk(pclk),
    .presetn(presetn),
    .wave(wave1)
  );

  indctl_blink_timer #(
    .HALF_CYCLES(RATE2_CYCLES)
  ) u_rate2 (
    .pclk(pclk),
    .presetn(presetn),
    .wave(wave2)
  );

  // indicator a and the multipurpose pin use system-side sources
  assign a_on = pin_state(indicator_a_control_ff, sys_src, 1'b1, wave1, wave2);
  assign mp_on = pin_state(multipurpose_pin_control_ff, sys_src, 1'b1, wave1, wave2);

  // indicator b uses line-side sources and no mix codes
  assign b_own_on = pin_state(indicator_b_control_ff, line_src, 1'b0, wave1, wave2);
  assign dual_mode = (indicator_a_control_ff[DUAL_LSB +: 2] == DUAL_SEL);
  // dual mode drives a bi-colour pair: b is the complement of a
  assign b_on = dual_mode ? ~a_on : b_own_on;

  indctl_pin_drive u_drive_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin_on(a_on),
    .sense(indicator_a_control_ff[SENSE_LSB +: 2]),
    .pin(indicator_a_pin)
  );

  // in dual mode b keeps its own drive sense, only the behaviour and rate fields are overridden
  indctl_pin_drive u_drive_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin_on(b_on),
    .sense(indicator_b_control_ff[SENSE_LSB +: 2]),
    .pin(indicator_b_pin)
  );

  indctl_pin_drive u_drive_mp (
    .pclk(pclk),
    .presetn(presetn),
    .pin_on(mp_on),
    .sense(multipurpose_pin_control_ff[SENSE_LSB +: 2]),
    .pin(multipurpose_pin)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_b_full;
    psel && penable && pwrite && hit_b && (pstrb == 4'hf);
  endsequence

  sequence s_rd_a;
    (psel && !penable && !pwrite && hit_a) ##1 (psel && penable);
  endsequence

  chk_blink_override: assert property (
    (indicator_a_control_ff[FLASH_LSB +: 4] == CODE_ON) |->
      (a_on == (indicator_a_control_ff[RATE_BIT] ? wave2 : wave1)))
    else $error("blink did not override solid on indicator a");

  chk_code_off_on: assert property (
    (multipurpose_pin_control_ff[FLASH_LSB +: 4] == CODE_OFF) |->
      ((multipurpose_pin_control_ff[STEADY_LSB +: 4] != CODE_OFF) || !mp_on) &&
      ((multipurpose_pin_control_ff[STEADY_LSB +: 4] != CODE_ON) || mp_on) &&
      ((multipurpose_pin_control_ff[STEADY_LSB +: 4] != CODE_TXRX) ||
        (mp_on == (sys_src.tx | sys_src.rx))))
    else $error("off, on or activity code wrong");

  chk_tx_rx_only: assert property (
    (indicator_a_control_ff[FLASH_LSB +: 4] == CODE_OFF) |->
      ((indicator_a_control_ff[STEADY_LSB +: 4] != CODE_TX) || (a_on == sys_src.tx)) &&
      ((indicator_a_control_ff[STEADY_LSB +: 4] != CODE_RX) || (a_on == sys_src.rx)))
    else $error("tx or rx only code wrong");

  chk_link_solid: assert property (
    (indicator_a_control_ff[FLASH_LSB +: 4] == CODE_OFF) &&
    (indicator_a_control_ff[STEADY_LSB +: 4] == CODE_LINK) |-> (a_on == sys_src.link))
    else $error("system link solid code wrong");

  chk_line_source: assert property (
    !dual_mode && (indicator_b_control_ff[FLASH_LSB +: 4] == CODE_OFF) &&
    (indicator_b_control_ff[STEADY_LSB +: 4] == CODE_LINK) |-> (b_on == line_src.link))
    else $error("indicator b not following line link");

  chk_dual_ignore: assert property (
    dual_mode |=> (indicator_b_pin.oe_n == $past(indicator_b_control_ff[1] & a_on)))
    else $error("indicator b fields not ignored in dual mode");

  chk_solid_mix: assert property (
    (multipurpose_pin_control_ff[FLASH_LSB +: 4] == CODE_SOLID_MIX) |-> mp_on)
    else $error("solid mix did not light the pin");

  chk_rate_pick: assert property (
    (multipurpose_pin_control_ff[FLASH_LSB +: 4] == CODE_BLINK_MIX) |->
      (mp_on == (multipurpose_pin_control_ff[RATE_BIT] ? wave2 : wave1)))
    else $error("wrong blink rate selected");

  chk_pin_polarity: assert property (
    (indicator_a_control_ff[SENSE_LSB +: 2] == SENSE_LOW_PUSH) && a_on |=>
      !indicator_a_pin.level && !indicator_a_pin.oe_n)
    else $error("indicator a not driven low when on");

  chk_write_mask: assert property (
    s_wr_b_full |=> (indicator_b_control_ff == ($past(pwdata[15:0]) & CTL_WMASK)))
    else $error("reserved bits not masked on write");

  chk_read_back: assert property (
    s_rd_a |-> (prdata == {16'h0000, indicator_a_control_ff}) && (prdata[3] == 1'b0))
    else $error("readback of indicator a wrong");

  chk_unmapped_err: assert property (
    (psel && penable && !mapped) |-> pslverr && pready ##1
      ($stable(indicator_a_control_ff) && $stable(indicator_b_control_ff) &&
       $stable(multipurpose_pin_control_ff)))
    else $error("unmapped access not refused");

  chk_dual_follow: assert property (
    dual_mode |-> (b_on == !a_on))
    else $error("indicator b did not follow a in dual mode");

  chk_line_activity: assert property (
    !dual_mode && (indicator_b_control_ff[FLASH_LSB +: 4] == CODE_OFF) &&
    (indicator_b_control_ff[STEADY_LSB +: 4] == CODE_TXRX) |->
      (b_on == (line_src.tx | line_src.rx)))
    else $error("indicator b not following line activity");

  chk_reserved_solid: assert property (
    (multipurpose_pin_control_ff[FLASH_LSB +: 4] == CODE_OFF) &&
    multipurpose_pin_control_ff[STEADY_LSB + 3] |-> !mp_on)
    else $error("reserved solid code lit the pin");

  chk_b_blink_reserved: assert property (
    !dual_mode && indicator_b_control_ff[FLASH_LSB + 3] &&
    (indicator_b_control_ff[STEADY_LSB +: 4] == CODE_OFF) |-> !b_on)
    else $error("reserved blink code lit indicator b");

  chk_mp_polarity: assert property (
    (multipurpose_pin_control_ff[SENSE_LSB +: 2] == SENSE_HIGH_PUSH) |=>
      (multipurpose_pin.level == $past(mp_on)) && !multipurpose_pin.oe_n)
    else $error("multipurpose pin not driven high when on");

  // byte lanes let software touch one field without a read-modify-write
  chk_write_lane: assert property (
    (psel && penable && pwrite && hit_mp && (pstrb == 4'h2)) |=>
      (multipurpose_pin_control_ff[7:0] == $past(multipurpose_pin_control_ff[7:0])))
    else $error("unstrobed byte lane changed");

endmodule // indctl_top

/* tb/indctl_lamp_model.sv */
`timescale 1ns/100ps
module indctl_lamp_model (
  input wire indctl_pkg::indctl_pin_t pin,
  output logic pad
);
  import indctl_pkg::*;
  logic last_ff;
  initial last_ff = 1'b1;
  always @(pin) if (!pin.oe_n) last_ff = pin.level;
  // board net has no pull, so a released pad shows the inverse of the last drive
  assign pad = pin.oe_n ? ~last_ff : pin.level;
endmodule // indctl_lamp_model

/* tb/indctl_top_test.sv */
`timescale 1ns/100ps
module indctl_top_test;
  import indctl_pkg::*;
  localparam int unsigned R1 = 4;
  localparam int unsigned R2 = 7;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  indctl_src_t sys_src, line_src;
  indctl_pin_t pin_a, pin_b, pin_m;
  logic pad_a, pad_b, pad_m;
  int n_errors, checks, cyc;
  logic [31:0] addrs [3];
  logic [31:0] rsts [3];

  indctl_top #(.RATE1_CYCLES(R1), .RATE2_CYCLES(R2)) indctl_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_src(sys_src), .line_src(line_src),
    .indicator_a_pin(pin_a), .indicator_b_pin(pin_b), .multipurpose_pin(pin_m));
  indctl_lamp_model lamp_a_i (.pin(pin_a), .pad(pad_a));
  indctl_lamp_model lamp_b_i (.pin(pin_b), .pad(pad_b));
  indctl_lamp_model lamp_m_i (.pin(pin_m), .pad(pad_m));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("MISMATCH t=%0t run timed out", $time);
      stop_test();
    end
  end

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // released pins are judged on oe_n only; the level behind a released pad is free
  task automatic cmp_pin(input indctl_pin_t got, input logic on, input logic [1:0] sense,
                         input string what);
    logic rel;
    logic lvl;
    rel = sense[1] & ~on;
    lvl = sense[1] ? sense[0] : (on ~^ sense[0]);
    checks++;
    if (got.oe_n !== rel || (!rel && got.level !== lvl)) begin
      n_errors++;
      $display("MISMATCH t=%0t %s pin %b exp on %b", $time, what, got, on);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
    apb(1'b1, ADDR_IND_A, {16'h0, a}, 4'hf);
    apb(1'b1, ADDR_IND_B, {16'h0, b}, 4'hf);
    apb(1'b1, ADDR_MP, {16'h0, m}, 4'hf);
    repeat (2) @(posedge pclk);
  endtask

  function automatic logic hit(input logic [3:0] c, input logic [2:0] s);
    case (c)
      4'h1: return s[2] | s[1];
      4'h2: return s[2];
      4'h3: return s[1];
      4'h6: return s[0];
      4'h7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // 56 cycles is a whole number of half periods of both rates, so phase does not matter
  task automatic blink_run(input int ea, input int eb, input int em, input logic ph);
    int na, nb, nm, skew;
    logic la, lb, lm;
    na = 0;
    nb = 0;
    nm = 0;
    skew = 0;
    la = pin_a.level;
    lb = pin_b.level;
    lm = pin_m.level;
    repeat (56) begin
      @(posedge pclk);
      na += int'(pin_a.level !== la);
      nb += int'(pin_b.level !== lb);
      nm += int'(pin_m.level !== lm);
      skew += int'(pin_a.level !== pin_m.level);
      la = pin_a.level;
      lb = pin_b.level;
      lm = pin_m.level;
    end
    cmp32(32'(na), 32'(ea), "a toggles");
    cmp32(32'(nb), 32'(eb), "b toggles");
    cmp32(32'(nm), 32'(em), "m toggles");
    if (ph) cmp32(32'(skew), 32'h0, "a m phase");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    sys_src = '0;
    line_src = '0;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    addrs = '{ADDR_IND_A, ADDR_IND_B, ADDR_MP};
    rsts = '{32'h0160, 32'h0160, 32'h0000};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    cmp_pin(pin_a, 1'b0, 2'h0, "a reset");
    cmp_pin(pin_m, 1'b0, 2'h0, "m reset");
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, addrs[i], 32'h0, 4'h0);
      cmp32(rd, rsts[i], "reset value");
      apb(1'b1, addrs[i], 32'hffffffff, 4'hf);
      apb(1'b0, addrs[i], 32'h0, 4'h0);
      cmp32(rd, 32'h00000ff7, "write mask");
    end
    apb(1'b1, ADDR_MP, 32'h0, 4'h2);
    apb(1'b0, ADDR_MP, 32'h0, 4'h0);
    cmp32(rd, 32'h000000f7, "lane write");
    apb(1'b0, 32'h0003c08c, 32'h0, 4'h0);
    cmp32(rd, 32'h0, "unmapped data");
    cmp32({31'h0, err}, 32'h1, "unmapped err");
    // solid codes, reserved ones included; line side gets the inverse pattern
    for (int c = 0; c < 9; c++) begin
      cfg({8'h0, c[3:0], 4'h1}, {8'h0, c[3:0], 4'h1}, {8'h0, c[3:0], 4'h1});
      for (int s = 0; s < 8; s++) begin
        sys_src <= s[2:0];
        line_src <= ~s[2:0];
        repeat (2) @(posedge pclk);
        cmp_pin(pin_a, hit(c[3:0], s[2:0]), 2'h1, "a solid");
        cmp_pin(pin_b, hit(c[3:0], ~s[2:0]), 2'h1, "b solid");
        cmp_pin(pin_m, hit(c[3:0], s[2:0]), 2'h1, "m solid");
      end
    end
    sys_src <= '0;
    line_src <= '0;
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, ADDR_IND_A, {24'h0, (k[0] ? 4'h7 : 4'h0), 2'h0, k[2:1]}, 4'hf);
      repeat (2) @(posedge pclk);
      cmp_pin(pin_a, k[0], k[2:1], "a sense");
      cmp32({31'h0, pad_a}, {31'h0, (k[2] ? k[1] : ~^k[1:0])}, "a pad");
    end
    cfg(16'h0701, 16'h0701, 16'h0a01);
    blink_run(14, 14, 14, 1'b1);
    cfg(16'h0705, 16'h0705, 16'h0a05);
    blink_run(8, 8, 8, 1'b1);
    cfg(16'h0701, 16'h0b01, 16'h0a05);
    blink_run(14, 0, 8, 1'b0);
    cfg(16'h0c71, 16'h0601, 16'h0b01);
    blink_run(0, 0, 0, 1'b0);
    cmp_pin(pin_a, 1'b1, 2'h1, "a reserved blink");
    cmp_pin(pin_b, 1'b0, 2'h1, "b idle link");
    cmp_pin(pin_m, 1'b1, 2'h1, "m solid mix");
    cmp32({31'h0, pad_m}, 32'h1, "m pad");
    sys_src <= 3'h1;
    cfg(16'h0671, 16'h0671, 16'h0c01);
    blink_run(14, 0, 0, 1'b0);
    cfg(16'h0871, 16'h0071, 16'h0000);
    cmp_pin(pin_b, 1'b0, 2'h1, "b dual off");
    cmp32({31'h0, pad_b}, 32'h0, "b pad off");
    cfg(16'h0801, 16'h0001, 16'h0000);
    cmp_pin(pin_b, 1'b1, 2'h1, "b dual on");
    cmp32({31'h0, pad_b}, 32'h1, "b pad on");
    stop_test();
  end
endmodule // indctl_top_test
